/* verilog/lpd_deser.sv */
`timescale 1ns/1ns
module lpd_deser #(
  parameter bit WIDE     = 1'b1,
  parameter int LOCK_CYC = lpd_pkg::LOCK_CYC
) (
  // System clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Link side: sampling clock from the seven-phase loop and the sampled lanes
  input  wire logic                        link_bit_clk,
  input  wire logic                        link_clock_in,
  input  wire logic [lpd_pkg::WIDE_LANES-1:0] serial_lane_in,
  // Power control
  input  wire logic                        sleep_request_n,
  // Parallel pixel outputs
  output logic                             word_strobe_clock_out,
  output logic [lpd_pkg::WORD_W-1:0]       parallel_word_out,
  output logic                             line_sync_out,
  output logic                             frame_sync_out,
  output logic                             pixel_valid_out,
  output logic                             aux_control_bit,
  // Status
  output logic                             loop_locked,
  output logic                             lock_timeout,
  output logic                             word_overrun
);

  localparam int NL = WIDE ? lpd_pkg::WIDE_LANES : lpd_pkg::NARROW_LANES;
  localparam int BL = lpd_pkg::BITS_PER_LANE;
  localparam int WW = lpd_pkg::WORD_W;
  localparam int TW = lpd_pkg::TIMER_W;
  localparam int LOCK_W = $clog2(LOCK_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset and sleep arrive through three-flop synchronisers.

  logic [2:0] lrst_sync_q;
  logic [2:0] lsleep_sync_q;
  logic       link_rst_q;
  logic       link_awake_q;

  always_ff @(posedge link_bit_clk) begin
    lrst_sync_q   <= {lrst_sync_q[1:0], sys_rst};
    lsleep_sync_q <= {lsleep_sync_q[1:0], sleep_request_n};
  end

  always_ff @(posedge link_bit_clk) begin
    if (lrst_sync_q[1] == lrst_sync_q[2]) begin
      link_rst_q <= lrst_sync_q[2];
    end
    if (lsleep_sync_q[1] == lsleep_sync_q[2]) begin
      link_awake_q <= lsleep_sync_q[2];
    end
  end

  wire link_hold = link_rst_q || !link_awake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: seven samples per period framed by the clock lane.

  logic          clk_lane_q;
  logic [2:0]    bit_idx_q;
  logic [3:0]    good_cnt_q;
  logic          locked_q;
  logic [WW-1:0] shift_q;
  logic [WW-1:0] hold_word_q;
  logic          req_tgl_q;
  logic          ack_tgl_q;
  logic [2:0]    ack_sync_q;
  logic          ack_seen_q;
  logic          overrun_tgl_q;

  // A low-to-high step of the clock lane marks bit 0 of a new period.
  wire frame_start = link_clock_in && !clk_lane_q;
  wire period_ok   = (bit_idx_q == lpd_pkg::LAST_BIT);

  always_ff @(posedge link_bit_clk) begin
    clk_lane_q <= link_clock_in;
  end

  always_ff @(posedge link_bit_clk) begin
    if (link_hold) begin
      bit_idx_q <= '0;
    end else if (frame_start) begin
      bit_idx_q <= '0;
    end else if (bit_idx_q != lpd_pkg::LAST_BIT) begin
      bit_idx_q <= bit_idx_q + 3'h1;
    end
  end

  // Lock needs a run of correctly framed periods; any misframe drops it.
  always_ff @(posedge link_bit_clk) begin
    if (link_hold) begin
      good_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (frame_start) begin
      if (!period_ok) begin
        good_cnt_q <= '0;
        locked_q   <= 1'b0;
      end else if (good_cnt_q != lpd_pkg::LOCK_PERIODS) begin
        good_cnt_q <= good_cnt_q + 4'h1;
      end else begin
        locked_q   <= 1'b1;
      end
    end else if (bit_idx_q == lpd_pkg::LAST_BIT && !link_clock_in && !clk_lane_q) begin
      good_cnt_q <= '0;
      locked_q   <= 1'b0;
    end
  end

  // Lane l bit b lands at word position l*7+b, the transmitter's own order.
  genvar gl;
  generate
    for (gl = 0; gl < lpd_pkg::WIDE_LANES; gl++) begin : g_lane
      if (gl < NL) begin : g_used
        always_ff @(posedge link_bit_clk) begin
          shift_q[gl*BL +: BL] <= {serial_lane_in[gl], shift_q[gl*BL+1 +: BL-1]};
        end
      end else begin : g_unused
        always_ff @(posedge link_bit_clk) begin
          shift_q[gl*BL +: BL] <= '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge link_bit_clk) begin
    ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
  end

  always_ff @(posedge link_bit_clk) begin
    if (link_rst_q) begin
      ack_seen_q <= 1'b0;
    end else if (ack_sync_q[1] == ack_sync_q[2]) begin
      ack_seen_q <= ack_sync_q[2];
    end
  end

  // The held word stays still until the system side acknowledges it.
  always_ff @(posedge link_bit_clk) begin
    if (link_rst_q) begin
      req_tgl_q     <= 1'b0;
      overrun_tgl_q <= 1'b0;
      hold_word_q   <= '0;
    end else if (frame_start && period_ok && locked_q && link_awake_q) begin
      if (req_tgl_q == ack_seen_q) begin
        hold_word_q <= shift_q;
        req_tgl_q   <= !req_tgl_q;
      end else begin
        overrun_tgl_q <= !overrun_tgl_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: synchronisers for sleep, lock, request and overrun.

  logic [2:0] sleep_sync_q;
  logic [2:0] lock_sync_q;
  logic [2:0] req_sync_q;
  logic [2:0] ovr_sync_q;
  logic       awake_q;
  logic       locked_s_q;
  logic       req_seen_q;
  logic       ovr_seen_q;

  always_ff @(posedge clk) begin
    sleep_sync_q <= {sleep_sync_q[1:0], sleep_request_n};
    lock_sync_q  <= {lock_sync_q[1:0], locked_q};
    req_sync_q   <= {req_sync_q[1:0], req_tgl_q};
    ovr_sync_q   <= {ovr_sync_q[1:0], overrun_tgl_q};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awake_q    <= 1'b0;
      locked_s_q <= 1'b0;
      req_seen_q <= 1'b0;
      ovr_seen_q <= 1'b0;
    end else begin
      if (sleep_sync_q[1] == sleep_sync_q[2]) begin
        awake_q <= sleep_sync_q[2];
      end
      if (lock_sync_q[1] == lock_sync_q[2]) begin
        locked_s_q <= lock_sync_q[2];
      end
      if (req_sync_q[1] == req_sync_q[2]) begin
        req_seen_q <= req_sync_q[2];
      end
      if (ovr_sync_q[1] == ovr_sync_q[2]) begin
        ovr_seen_q <= ovr_sync_q[2];
      end
    end
  end

  wire run       = awake_q && locked_s_q;
  wire word_new  = req_seen_q != ack_tgl_q;
  logic fifo_in_ready;

  // While running, an acknowledge only goes back once the buffer took the word, so a full
  // buffer stalls the link side instead of silently losing data.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_tgl_q <= 1'b0;
    end else if (word_new && (fifo_in_ready || !run)) begin
      ack_tgl_q <= req_seen_q;
    end
  end

  logic ovr_prev_q;
  logic overrun_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovr_prev_q <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      ovr_prev_q <= ovr_seen_q;
      overrun_q  <= (ovr_prev_q != ovr_seen_q) || (overrun_q && run);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period measurement: the spacing of arriving words gives the link period.

  logic [TW-1:0] gap_cnt_q;
  logic [TW-1:0] period_q;
  wire           word_take = word_new && fifo_in_ready && run;

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      gap_cnt_q <= '0;
      period_q  <= '0;
    end else if (word_take) begin
      gap_cnt_q <= {{(TW-1){1'b0}}, 1'b1};
      period_q  <= gap_cnt_q;
    end else if (gap_cnt_q != '0 && gap_cnt_q != '1) begin
      // The count idles at zero until the first word, so the first spacing is never a guess.
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  wire [TW-1:0] half_hi = {1'b0, period_q[TW-1:1]} + {{(TW-1){1'b0}}, period_q[0]};
  wire [TW-1:0] half_lo = {1'b0, period_q[TW-1:1]};

  ////////////////////////////////////////////////////////////////////////////
  // Elastic buffer and output pacing.

  logic          fifo_out_valid;
  logic [WW-1:0] fifo_out_data;
  logic          pace_pop;

  lpd_fifo #(
    .WIDTH (WW),
    .DEPTH (lpd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (!run),
    .in_valid  (word_new && run),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_word_q),
    .out_ready (pace_pop),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data)
  );

  lpd_pkg::lpd_pace_t pace_q;
  logic [TW-1:0]      pace_tmr_q;
  logic               strobe_q;
  logic [WW-1:0]      word_q;

  wire period_known = (period_q > {{(TW-2){1'b0}}, 2'h1});
  wire slot_free    = (pace_q == lpd_pkg::PACE_IDLE) ||
                      (pace_q == lpd_pkg::PACE_LOW && pace_tmr_q == '0);
  assign pace_pop   = run && period_known && slot_free && fifo_out_valid;

  // One word per output period: high half then low half, data change on the
  // rising edge so the falling edge sits mid-word for the sink to sample.
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      pace_q     <= lpd_pkg::PACE_IDLE;
      pace_tmr_q <= '0;
      strobe_q   <= 1'b0;
    end else if (pace_pop) begin
      pace_q     <= lpd_pkg::PACE_HIGH;
      pace_tmr_q <= half_hi - 1'b1;
      strobe_q   <= 1'b1;
    end else begin
      case (pace_q)
        lpd_pkg::PACE_HIGH: begin
          if (pace_tmr_q == '0) begin
            pace_q     <= lpd_pkg::PACE_LOW;
            pace_tmr_q <= half_lo - 1'b1;
            strobe_q   <= 1'b0;
          end else begin
            pace_tmr_q <= pace_tmr_q - 1'b1;
          end
        end
        lpd_pkg::PACE_LOW: begin
          if (pace_tmr_q == '0) begin
            pace_q <= lpd_pkg::PACE_IDLE;
          end else begin
            pace_tmr_q <= pace_tmr_q - 1'b1;
          end
        end
        default: begin
          pace_q <= lpd_pkg::PACE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      word_q <= '0;
    end else if (pace_pop) begin
      word_q <= fifo_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock watchdog: flags a loop that has not locked in its allowed time.

  logic [LOCK_W-1:0] lock_tmr_q;
  logic              lock_to_q;

  always_ff @(posedge clk) begin
    if (sys_rst || !awake_q || locked_s_q) begin
      lock_tmr_q <= '0;
      lock_to_q  <= 1'b0;
    end else if (lock_tmr_q == LOCK_W'(LOCK_CYC)) begin
      lock_to_q  <= 1'b1;
    end else begin
      lock_tmr_q <= lock_tmr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output fields.

  assign word_strobe_clock_out = strobe_q;
  assign parallel_word_out     = word_q;
  assign line_sync_out   = WIDE ? word_q[lpd_pkg::HSYNC_POS] : word_q[lpd_pkg::HSYNC_POS_N];
  assign frame_sync_out  = WIDE ? word_q[lpd_pkg::VSYNC_POS] : word_q[lpd_pkg::VSYNC_POS_N];
  assign pixel_valid_out = WIDE ? word_q[lpd_pkg::DE_POS]    : word_q[lpd_pkg::DE_POS_N];
  assign aux_control_bit = WIDE ? word_q[lpd_pkg::AUX_POS]   : 1'b0;
  assign loop_locked     = locked_s_q;
  assign lock_timeout    = lock_to_q;
  assign word_overrun    = overrun_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  int unsigned high_len_q;

  always_ff @(posedge clk) begin
    if (sys_rst || !strobe_q) begin
      high_len_q <= 0;
    end else begin
      high_len_q <= high_len_q + 1;
    end
  end

  AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    !sleep_request_n [*8] |-> (word_q == '0 && !strobe_q))
    else $error("outputs not low during sleep");

  AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !awake_q |=> (word_q == '0))
    else $error("data not cleared while asleep");

  AST_UNLOCK_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(locked_s_q) |=> (word_q == '0 && !strobe_q))
    else $error("outputs not held low after loss of lock");

  AST_HIGH_HALF: assert property (@(posedge clk) disable iff (sys_rst || !run)
    $fell(strobe_q) |-> (high_len_q == 32'(half_hi)))
    else $error("output clock high time differs from half period");

  AST_DATA_ON_RISE: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(word_q) && run |-> $rose(strobe_q))
    else $error("data changed away from rising strobe");

  AST_DATA_STABLE_FALL: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(strobe_q) && run |-> $stable(word_q))
    else $error("data moved at the sampling edge");

  AST_LOCK_NEEDS_RUN: assert property (@(posedge link_bit_clk) disable iff (link_rst_q)
    $rose(locked_q) |-> $past(good_cnt_q) == lpd_pkg::LOCK_PERIODS)
    else $error("lock taken before enough good periods");

  AST_BIT_INDEX: assert property (@(posedge link_bit_clk) disable iff (link_hold)
    frame_start |=> (bit_idx_q == 3'h0) ##1 (bit_idx_q == 3'h1 || frame_start))
    else $error("bit index not restarted at period start");

  AST_HOLD_STABLE: assert property (@(posedge link_bit_clk) disable iff (link_rst_q)
    (req_tgl_q != ack_seen_q) && $past(req_tgl_q != ack_seen_q) |-> $stable(hold_word_q))
    else $error("held word changed before acknowledge");

  AST_NARROW_AUX: assert property (@(posedge clk) disable iff (sys_rst)
    !WIDE |-> (word_q[WW-1:lpd_pkg::NARROW_W] == '0 && aux_control_bit == 1'b0))
    else $error("aux bit driven in narrow variant");

endmodule : lpd_deser

/* include/lpd_pkg.sv */
// Notes on behaviour
// - Wide variant turns four lanes into 28 bits: 24 colour, 4 control each period.
// - Narrow variant turns three lanes into 21 bits: 18 colour, 3 control.
// - Output words are meant to be sampled on the falling edge of the output clock.
// - Either transmitter strobe edge is accepted; only the serial framing matters.
// - Link clock lies within 20 to 65 MHz; the output pacing needs at least two 25 MHz system cycles per period, so it cannot follow above 12.5 MHz.
// - Output clock runs at the link clock frequency, high for half the period rounded up, low for the rest.
// - While sleep_request_n is low, every parallel output is driven low.
// - Each lane is sampled seven times per link period, bit 0 to bit 6 in order.
// - Seven-phase sampling is derived from the link clock with no external parts; the code takes its sampling clock in on link_bit_clk.
// - The sampling loop locks within 10 ms; data before lock are not trusted.
// - Outputs are forced low within 1 us of sleep_request_n going low.
// - Control outputs give line sync, frame sync, data valid beside 8-bit colour fields; the narrow variant has 6-bit fields.
package lpd_pkg;

  // Serial framing.
  localparam int          BITS_PER_LANE  = 7;
  localparam int          WIDE_LANES     = 4;
  localparam int          NARROW_LANES   = 3;
  localparam int          WORD_W         = BITS_PER_LANE * WIDE_LANES;
  localparam logic [2:0]  LAST_BIT       = 3'h6;
  localparam logic [3:0]  LOCK_PERIODS   = 4'h8;

  // Parallel word layout, colour fields first, control bits above them.
  localparam int          COLOUR_W       = 8;
  localparam int          COLOUR_W_N     = 6;
  localparam int          HSYNC_POS      = 24;
  localparam int          VSYNC_POS      = 25;
  localparam int          DE_POS         = 26;
  localparam int          AUX_POS        = 27;
  localparam int          HSYNC_POS_N    = 18;
  localparam int          VSYNC_POS_N    = 19;
  localparam int          DE_POS_N       = 20;
  localparam int          NARROW_W       = 21;

  // Timing figures in their own units and in 25 MHz system clock cycles.
  localparam int          CLK_MHZ        = 25;
  localparam int          LINK_MIN_MHZ   = 20;
  localparam int          LINK_MAX_MHZ   = 65;
  localparam int          LOCK_TIME_MS   = 10;
  localparam int          LOCK_CYC       = LOCK_TIME_MS * 1000 * CLK_MHZ;
  localparam int          SLEEP_DELAY_US = 1;
  localparam int          SLEEP_CYC      = SLEEP_DELAY_US * CLK_MHZ;

  // Elastic buffer between link and output pacing.
  localparam int          FIFO_DEPTH     = 16;
  localparam int          TIMER_W        = 12;

  typedef enum logic [1:0] {
    PACE_IDLE,
    PACE_HIGH,
    PACE_LOW
  } lpd_pace_t;

endpackage : lpd_pkg

/* verilog/lpd_fifo.sv */
`timescale 1ns/1ns
module lpd_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             push;
  logic             pull;

  // The register stage adds one word of room beyond DEPTH.
  assign in_ready  = (count_q != (AW+1)'(DEPTH)) && !flush;
  assign push      = in_valid && in_ready;
  assign pull      = (count_q != '0) && (!out_valid_q || out_ready) && !flush;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pull) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (pull) begin
      out_valid_q <= 1'b1;
      out_data_q  <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule : lpd_fifo

/* testbench/lpd_tx_model.sv */
`timescale 1ns/1ns
module lpd_tx_model (
  // Link bit clock
  input  wire logic        link_bit_clk,
  // Bench control
  input  wire logic        tx_en,
  input  wire logic        bad_frame,
  input  wire logic [27:0] tx_word,
  // Serial lanes
  output logic             link_clock_in,
  output logic [3:0]       serial_lane_in
);
  logic [2:0]  bit_q;
  logic [27:0] cur_q;

  initial begin
    bit_q          = 3'h0;
    cur_q          = 28'h0;
    link_clock_in  = 1'b0;
    serial_lane_in = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bits change on the falling edge so that they are settled at the sampling rise.
  always @(negedge link_bit_clk) begin
    logic [27:0] w;
    w = (bit_q == 3'h0) ? tx_word : cur_q;
    if (!tx_en) begin
      // The clock lane stands low and data lanes toggle, so stale bits never look valid.
      link_clock_in  <= 1'b0;
      serial_lane_in <= ~serial_lane_in;
      bit_q          <= 3'h0;
    end else begin
      cur_q         <= w;
      link_clock_in <= (bit_q < 3'h4);
      for (int l = 0; l < 4; l++) begin
        serial_lane_in[l] <= w[7*l + bit_q];
      end
      // A six-bit period is a framing fault that the receiver must refuse.
      bit_q <= (bit_q == (bad_frame ? 3'h5 : 3'h6)) ? 3'h0 : bit_q + 3'h1;
    end
  end
endmodule : lpd_tx_model

/* testbench/lpd_deser_tb_top.sv */
`timescale 1ns/1ns
module lpd_deser_tb_top;
  localparam int LOCK_SIM = 200;
  localparam int LIMIT    = 30000;
  logic        clk, link_bit_clk, sys_rst, sleep_request_n, tx_en, bad_frame;
  logic [27:0] tx_word, word, n_word;
  logic        link_clock_in, strobe, lsync, fsync, pvalid, aux, locked, tmo, ovr;
  logic        n_strobe, n_lsync, n_fsync, n_valid, n_aux;
  logic [3:0]  serial_lane_in;
  int          n_fail, checked, cycles;

  initial clk = 1'b0;
  always #20 clk = ~clk;
  initial begin
    link_bit_clk = 1'b0;
    #13;
    forever #80 link_bit_clk = ~link_bit_clk;
  end

  lpd_tx_model u_tx (.link_bit_clk(link_bit_clk), .tx_en(tx_en), .bad_frame(bad_frame), .tx_word(tx_word),
    .link_clock_in(link_clock_in), .serial_lane_in(serial_lane_in));

  lpd_deser #(.WIDE(1'b1), .LOCK_CYC(LOCK_SIM)) u_dut (.clk(clk), .sys_rst(sys_rst), .link_bit_clk(link_bit_clk),
    .link_clock_in(link_clock_in), .serial_lane_in(serial_lane_in), .sleep_request_n(sleep_request_n),
    .word_strobe_clock_out(strobe), .parallel_word_out(word), .line_sync_out(lsync), .frame_sync_out(fsync),
    .pixel_valid_out(pvalid), .aux_control_bit(aux), .loop_locked(locked), .lock_timeout(tmo), .word_overrun(ovr));

  lpd_deser #(.WIDE(1'b0), .LOCK_CYC(LOCK_SIM)) u_dut_n (.clk(clk), .sys_rst(sys_rst), .link_bit_clk(link_bit_clk),
    .link_clock_in(link_clock_in), .serial_lane_in(serial_lane_in), .sleep_request_n(sleep_request_n),
    .word_strobe_clock_out(n_strobe), .parallel_word_out(n_word), .line_sync_out(n_lsync),
    .frame_sync_out(n_fsync), .pixel_valid_out(n_valid), .aux_control_bit(n_aux), .loop_locked(),
    .lock_timeout(), .word_overrun());

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks=%0d failures=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic wait_level(input logic lvl, output int n);
    n = 0;
    while (strobe !== lvl && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_level

  task automatic wait_fall;
    int n;
    wait_level(1'b1, n);
    wait_level(1'b0, n);
  endtask : wait_fall

  task automatic wait_lock(input logic want);
    int n;
    n = 0;
    while (locked !== want && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(28'(locked), 28'(want));
  endtask : wait_lock

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    repeat (LOCK_SIM + 20) @(negedge clk);
    check(28'(tmo), 28'h1);
    check(word, 28'h0);
    check(28'({strobe, locked}), 28'h0);
  endtask : t_idle

  task automatic t_words;
    logic [27:0] tbl [4];
    tbl = '{28'hAAAAAAA, 28'h5555555, 28'h8000001, 28'h0F3C5A9};
    @(posedge clk);
    tx_en <= 1'b1;
    wait_lock(1'b1);
    foreach (tbl[i]) begin
      @(posedge clk);
      tx_word <= tbl[i];
      repeat (8) wait_fall;
      check(word, tbl[i]);
      check(28'({aux, pvalid, fsync, lsync}), 28'(tbl[i][27:24]));
      check(n_word, {7'h00, tbl[i][20:0]});
      check(28'({n_aux, n_valid, n_fsync, n_lsync}), {25'h0, tbl[i][20:18]});
      check(28'(n_strobe), 28'h0);
    end
  endtask : t_words

  task automatic t_duty;
    int lo, hi, hi_sum, all_sum;
    hi_sum  = 0;
    all_sum = 0;
    wait_fall;
    repeat (4) begin
      wait_level(1'b1, lo);
      wait_level(1'b0, hi);
      hi_sum  += hi;
      all_sum += lo + hi;
    end
    // One word spans 7 link bits of 160 ns, which is 28 system cycles.
    check(28'(all_sum), 28'(4 * 28));
    check(28'(hi_sum), 28'(4 * 14));
    check(28'(ovr), 28'h0);
  endtask : t_duty

  task automatic t_misframe;
    @(posedge clk);
    bad_frame <= 1'b1;
    repeat (28) @(posedge clk);
    bad_frame <= 1'b0;
    wait_lock(1'b0);
    repeat (3) @(negedge clk);
    check(word, 28'h0);
    wait_lock(1'b1);
  endtask : t_misframe

  task automatic t_sleep;
    int          n;
    logic [28:0] acc;
    n   = 0;
    acc = 29'h0;
    @(posedge clk);
    sleep_request_n <= 1'b0;
    @(negedge clk);
    while ((word !== 28'h0 || strobe !== 1'b0) && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(28'(n <= 25), 28'h1);
    repeat (100) begin
      @(negedge clk);
      acc |= {word, strobe};
    end
    check(acc[28:1], 28'h0);
    check(28'(acc[0]), 28'h0);
    @(posedge clk);
    sleep_request_n <= 1'b1;
    wait_lock(1'b1);
    repeat (8) wait_fall;
    check(word, tx_word);
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    n_fail          = 0;
    checked         = 0;
    cycles          = 0;
    sys_rst         = 1'b1;
    sleep_request_n = 1'b1;
    tx_en           = 1'b0;
    bad_frame       = 1'b0;
    tx_word         = 28'h0;
    // Eight cycles span two link bit edges, so the link side still sees the reset.
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_idle();
    t_words();
    t_duty();
    t_misframe();
    t_sleep();
    finish_test();
  end
endmodule : lpd_deser_tb_top
